// ---- hw/diic_pkg.sv ----
/*
  diic_pkg: constants, types and register map of the interrupt and idle controller.
  assumes: a 25 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
package diic_pkg;
  localparam int diic_nsrc = 11;
  localparam logic [13:0] diic_vec_reset = 14'h0000;
  localparam logic [13:0] diic_vec_pwd = 14'h002c;
  // index order = priority order, 0 highest after power-down
  localparam int diic_src_extb = 0;
  localparam int diic_src_lvlb = 1;
  localparam int diic_src_lvla = 2;
  localparam int diic_src_sp0tx = 3;
  localparam int diic_src_sp0rx = 4;
  localparam int diic_src_edge = 5;
  localparam int diic_src_byte_dma_port = 6;
  localparam int diic_src_sp1tx = 7;
  localparam int diic_src_sp1rx = 8;
  localparam int diic_src_timer = 9;
  localparam int diic_src_sw = 10;
  localparam logic [13:0] diic_vec_tbl [diic_nsrc] = '{
    14'h0004, 14'h0008, 14'h000c, 14'h0010, 14'h0014, 14'h0018,
    14'h001c, 14'h0020, 14'h0024, 14'h0028, 14'h0028};
  // byte addresses
  localparam logic [7:0] diic_adr_mask = 8'h00;
  localparam logic [7:0] diic_adr_ctrl = 8'h04;
  localparam logic [7:0] diic_adr_fclr = 8'h08;
  localparam logic [7:0] diic_adr_cmd = 8'h0c;
  localparam logic [7:0] diic_adr_stat = 8'h10;
  localparam logic [7:0] diic_adr_vec = 8'h14;
  // control register fields
  localparam int diic_ctl_nest = 3;
  localparam int diic_ctl_sp1irq = 4;
  localparam int diic_ctl_powerup_context_reset_bit = 5;
  localparam int diic_ctl_xtal = 6;
  // command register fields
  localparam int diic_cmd_ena = 0;
  localparam int diic_cmd_dis = 1;
  localparam int diic_cmd_idle = 2;
  localparam int diic_cmd_pwdf = 3;
  localparam int diic_cmd_ack = 4;
  localparam int diic_cmd_rti = 5;
  localparam int diic_cmd_div_lo = 8;
  localparam int diic_cmd_div_hi = 10;
  // idle divisor codes
  localparam logic [2:0] diic_div_none = 3'h0;
  localparam logic [2:0] diic_div_16 = 3'h1;
  localparam logic [2:0] diic_div_32 = 3'h2;
  localparam logic [2:0] diic_div_64 = 3'h3;
  localparam logic [2:0] diic_div_128 = 3'h4;
  localparam int diic_stack_depth = 12;
  localparam logic [1:0] diic_resp_okay = 2'h0;
  localparam logic [1:0] diic_resp_slverr = 2'h2;
  // power-down recovery, input clock is half the instruction rate
  localparam int diic_clock_input_ns = 80;
  localparam int diic_rec_clock_input = 200;
  localparam int diic_rec_xtal_clock_input = 4096;
  localparam int diic_clk_ns = 40;
  localparam int diic_rec_cyc = (diic_rec_clock_input * diic_clock_input_ns + diic_clk_ns - 1) / diic_clk_ns;
  localparam int diic_rec_xtal_cyc =
    (diic_rec_xtal_clock_input * diic_clock_input_ns + diic_clk_ns - 1) / diic_clk_ns;

  typedef enum logic [1:0] {
    diic_run = 2'b00,
    diic_idle = 2'b01,
    diic_pdown = 2'b11,
    diic_wake = 2'b10
  } diic_state_t;

  typedef struct packed {
    logic extb_n;
    logic lvla_n;
    logic lvlb_n;
    logic edge_n;
    logic alta_n;
    logic altb_n;
    logic pwd_n;
  } diic_pins_t;

  typedef struct packed {
    logic sp0tx;
    logic sp0rx;
    logic byte_dma_port;
    logic sp1tx;
    logic sp1rx;
    logic timer;
  } diic_int_t;
endpackage : diic_pkg

// ---- hw/diic_top.sv ----
/*
  diic_top: prioritised, maskable vectored interrupt controller with idle,
  slow idle and power-down control, registers over AXI4-Lite.
  assumes: pin inputs asynchronous; internal events one-cycle pulses on clk.
*/
`timescale 1ns/100ps
`default_nettype none
module diic_top #(
  parameter int rec_xtal_cyc = diic_pkg::diic_rec_xtal_cyc
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire diic_pkg::diic_pins_t pins,
  input wire diic_pkg::diic_int_t int_ev,
  input wire logic [11:0] status_in,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_req_ff,
  output logic [13:0] irq_vector_ff,
  output logic [11:0] status_out_ff,
  output logic ctx_clear_ff,
  output logic stall_ff,
  output logic steal_grant_ff,
  output logic clk_en_ff,
  output logic powerdown_acknowledge_pin_ff
);
  import diic_pkg::*;
  diic_pins_t sync1_ff, sync2_ff, sync3_ff;
  logic [diic_nsrc-1:0] mask_ff, pend_ff, act_ff, nxt_pend;
  logic [7:0] ctrl_ff;
  logic gie_ff, hold_ff, pwd_pend_ff;
  diic_state_t state_ff;
  logic [2:0] div_ff;
  logic [6:0] divcnt_ff;
  logic [12:0] reccnt_ff;
  logic [11:0] stack_ff [diic_stack_depth];
  logic [3:0] sp_ff;
  logic aw_ok_ff, w_ok_ff;
  logic [7:0] awa_ff;
  logic [31:0] wd_ff;
  logic [3:0] ws_ff;
  // two-flop synchronisers; third stage only for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= '1;
      sync2_ff <= '1;
      sync3_ff <= '1;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end
  // raw requests, active high, after pin polarity
  logic [diic_nsrc-1:0] lvl_in, edg_in;
  logic alt_on;
  always_comb begin
    alt_on = ctrl_ff[diic_ctl_sp1irq];
    lvl_in = '0;
    edg_in = '0;
    // pins read as seen, whether another chip or our flag output drives them
    lvl_in[diic_src_extb] = !sync2_ff.extb_n;
    edg_in[diic_src_extb] = !sync2_ff.extb_n && sync3_ff.extb_n;
    lvl_in[diic_src_lvlb] = !sync2_ff.lvlb_n;
    lvl_in[diic_src_lvla] = !sync2_ff.lvla_n;
    edg_in[diic_src_edge] = !sync2_ff.edge_n && sync3_ff.edge_n;
    edg_in[diic_src_sp0tx] = int_ev.sp0tx;
    edg_in[diic_src_sp0rx] = int_ev.sp0rx;
    edg_in[diic_src_byte_dma_port] = int_ev.byte_dma_port;
    edg_in[diic_src_timer] = int_ev.timer;
    lvl_in[diic_src_sp1tx] = alt_on && !sync2_ff.altb_n;
    edg_in[diic_src_sp1tx] = alt_on ? (!sync2_ff.altb_n && sync3_ff.altb_n) : int_ev.sp1tx;
    lvl_in[diic_src_sp1rx] = alt_on && !sync2_ff.alta_n;
    edg_in[diic_src_sp1rx] = alt_on ? (!sync2_ff.alta_n && sync3_ff.alta_n) : int_ev.sp1rx;
  end
  // level mode per source: control bits 0..2 pick extb, alt b, alt a
  logic [diic_nsrc-1:0] is_lvl;
  always_comb begin
    is_lvl = '0;
    is_lvl[diic_src_lvla] = 1'b1;
    is_lvl[diic_src_lvlb] = 1'b1;
    is_lvl[diic_src_extb] = ctrl_ff[0];
    is_lvl[diic_src_sp1tx] = alt_on && ctrl_ff[1];
    is_lvl[diic_src_sp1rx] = alt_on && ctrl_ff[2];
  end
  // priority select
  logic [diic_nsrc-1:0] req, eligible;
  logic sel_ok;
  logic [3:0] sel_idx;
  logic pwd_take;
  always_comb begin
    req = pend_ff | (lvl_in & is_lvl);
    eligible = req & mask_ff;
    // nesting lets only higher levels than the active ones through
    for (int i = 0; i < diic_nsrc; i++) begin
      for (int j = 0; j <= i; j++) begin
        if (act_ff[j] && !(ctrl_ff[diic_ctl_nest] && j > i)) begin
          eligible[i] = 1'b0;
        end
      end
    end
    sel_ok = 1'b0;
    sel_idx = 4'h0;
    for (int i = diic_nsrc - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        sel_ok = 1'b1;
        sel_idx = 4'(i);
      end
    end
    sel_ok = sel_ok && (ctrl_ff[diic_ctl_nest] || act_ff == '0);
    pwd_take = pwd_pend_ff && gie_ff && !hold_ff && !irq_req_ff;
  end
  logic take;
  assign take = sel_ok && gie_ff && !hold_ff && !irq_req_ff && !pwd_take;
  // bus decode
  logic wr_go, rd_go;
  assign wr_go = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  logic wr_mask, wr_ctrl, wr_fclr, wr_cmd;
  assign wr_mask = wr_go && awa_ff == diic_adr_mask && ws_ff[0];
  assign wr_ctrl = wr_go && awa_ff == diic_adr_ctrl && ws_ff[0];
  assign wr_fclr = wr_go && awa_ff == diic_adr_fclr && (&ws_ff[3:0]);
  assign wr_cmd = wr_go && awa_ff == diic_adr_cmd && ws_ff[0];
  // pending latches; hardware set wins over clear
  always_comb begin
    nxt_pend = pend_ff;
    if (wr_fclr) begin
      nxt_pend = nxt_pend & ~wd_ff[26:16];
    end
    if (take) begin
      nxt_pend[sel_idx] = 1'b0;
    end
    nxt_pend = nxt_pend | (edg_in & ~is_lvl);
    if (wr_fclr) begin
      nxt_pend = nxt_pend | wd_ff[10:0];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end
  // power-down request: pin falling edge only, cleared when taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwd_pend_ff <= 1'b0;
    end else if (!sync2_ff.pwd_n && sync3_ff.pwd_n) begin
      pwd_pend_ff <= 1'b1;
    end else if (pwd_take) begin
      pwd_pend_ff <= 1'b0;
    end
  end
  // mask, control, global enable, hold-off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ff <= '0;
      ctrl_ff <= '0;
      gie_ff <= 1'b1;
      hold_ff <= 1'b0;
    end else begin
      hold_ff <= wr_mask;
      if (wr_mask) begin
        mask_ff <= wd_ff[10:0];
      end
      if (wr_ctrl) begin
        ctrl_ff <= wd_ff[7:0];
      end
      if (wr_cmd && wd_ff[diic_cmd_ena]) begin
        gie_ff <= 1'b1;
      end else if (wr_cmd && wd_ff[diic_cmd_dis]) begin
        gie_ff <= 1'b0;
      end
    end
  end
  // vector out, active set and status stack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req_ff <= 1'b0;
      irq_vector_ff <= diic_vec_reset;
      act_ff <= '0;
      sp_ff <= '0;
      status_out_ff <= '0;
      for (int i = 0; i < diic_stack_depth; i++) begin
        stack_ff[i] <= '0;
      end
    end else begin
      if (pwd_take) begin
        irq_req_ff <= 1'b1;
        irq_vector_ff <= diic_vec_pwd;
      end else if (take) begin
        irq_req_ff <= 1'b1;
        irq_vector_ff <= diic_vec_tbl[sel_idx];
        act_ff[sel_idx] <= 1'b1;
      end else if (wr_cmd && wd_ff[diic_cmd_ack]) begin
        irq_req_ff <= 1'b0;
      end
      if ((pwd_take || take) && sp_ff < 4'(diic_stack_depth)) begin
        stack_ff[sp_ff] <= status_in;
        sp_ff <= sp_ff + 4'h1;
      end else if (wr_cmd && wd_ff[diic_cmd_rti] && sp_ff != 4'h0) begin
        status_out_ff <= stack_ff[sp_ff - 4'h1];
        sp_ff <= sp_ff - 4'h1;
        // lowest set bit is the most recent nest level
        for (int i = diic_nsrc - 1; i >= 0; i--) begin
          if (act_ff[i]) begin
            act_ff <= act_ff & ~(11'h001 << i);
          end
        end
      end
    end
  end
  // low-power state machine; a request accepted while idle keeps wake armed
  logic wake_ev;
  assign wake_ev = (sel_ok && gie_ff) || irq_req_ff;
  logic [6:0] div_n;
  always_comb begin
    unique case (div_ff)
      diic_div_16: div_n = 7'h0f;
      diic_div_32: div_n = 7'h1f;
      diic_div_64: div_n = 7'h3f;
      diic_div_128: div_n = 7'h7f;
      default: div_n = 7'h00;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= diic_run;
      div_ff <= diic_div_none;
      divcnt_ff <= '0;
      reccnt_ff <= '0;
      clk_en_ff <= 1'b1;
      stall_ff <= 1'b0;
      ctx_clear_ff <= 1'b0;
      powerdown_acknowledge_pin_ff <= 1'b0;
    end else begin
      ctx_clear_ff <= 1'b0;
      unique case (state_ff)
        diic_run: begin
          clk_en_ff <= 1'b1;
          if (wr_cmd && wd_ff[diic_cmd_pwdf]) begin
            state_ff <= diic_pdown;
            stall_ff <= 1'b1;
            powerdown_acknowledge_pin_ff <= 1'b1;
          end else if (wr_cmd && wd_ff[diic_cmd_idle]) begin
            state_ff <= diic_idle;
            stall_ff <= 1'b1;
            div_ff <= wd_ff[diic_cmd_div_hi:diic_cmd_div_lo];
            divcnt_ff <= '0;
          end
        end
        diic_idle: begin
          // one enable for core, serial, output and timer clocks: same ratio
          divcnt_ff <= (divcnt_ff == div_n) ? 7'h00 : divcnt_ff + 7'h01;
          clk_en_ff <= (divcnt_ff == div_n);
          if (wake_ev && divcnt_ff == div_n) begin
            state_ff <= diic_run;
            stall_ff <= 1'b0;
            clk_en_ff <= 1'b1;
          end
        end
        diic_pdown: begin
          clk_en_ff <= 1'b0;
          if (!sync2_ff.pwd_n && sync3_ff.pwd_n) begin
            state_ff <= diic_wake;
            reccnt_ff <= ctrl_ff[diic_ctl_xtal] ? 13'(rec_xtal_cyc - 1)
                                                : 13'(diic_rec_cyc - 1);
          end
        end
        diic_wake: begin
          if (reccnt_ff == 13'h0000) begin
            state_ff <= diic_run;
            stall_ff <= 1'b0;
            powerdown_acknowledge_pin_ff <= 1'b0;
            clk_en_ff <= 1'b1;
            ctx_clear_ff <= ctrl_ff[diic_ctl_powerup_context_reset_bit];
          end else begin
            reccnt_ff <= reccnt_ff - 13'h0001;
          end
        end
      endcase
    end
  end
  // dma and autobuffer steals never blocked by idle, hold-off or disable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      steal_grant_ff <= 1'b1;
    end else begin
      steal_grant_ff <= state_ff != diic_pdown;
    end
  end
  // axi4-lite slave
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awa_ff <= '0;
      wd_ff <= '0;
      ws_ff <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= diic_resp_okay;
    end else begin
      s_axi_awready <= !aw_ok_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_ok_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1;
        awa_ff <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1;
        wd_ff <= s_axi_wdata;
        ws_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awa_ff <= diic_adr_cmd && awa_ff[1:0] == 2'b00)
                       ? diic_resp_okay : diic_resp_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= diic_resp_okay;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= diic_resp_okay;
        unique case (s_axi_araddr[7:0])
          diic_adr_mask: s_axi_rdata <= {21'h0, mask_ff};
          diic_adr_ctrl: s_axi_rdata <= {24'h0, ctrl_ff};
          diic_adr_stat: s_axi_rdata <= {4'h0, sp_ff, 2'h0, state_ff, gie_ff,
                                         pwd_pend_ff, irq_req_ff, 6'h0, act_ff};
          diic_adr_vec: s_axi_rdata <= {5'h0, pend_ff, 2'h0, irq_vector_ff};
          default: begin
            // force/clear is write-only, command reads zero
            s_axi_rdata <= '0;
            if (s_axi_araddr[7:0] != diic_adr_fclr && s_axi_araddr[7:0] != diic_adr_cmd) begin
              s_axi_rresp <= diic_resp_slverr;
            end
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // diic_top

`default_nettype wire

// ---- tb/diic_asserts.sv ----
/*
  diic_asserts: port-level checks on the interrupt and idle controller.
  assumes: bound into diic_top; one clock domain, async active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module diic_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_req_ff,
  input wire logic [13:0] irq_vector_ff,
  input wire logic ctx_clear_ff,
  input wire logic stall_ff,
  input wire logic steal_grant_ff,
  input wire logic clk_en_ff,
  input wire logic powerdown_acknowledge_pin_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_rd_hs;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_hs;
    s_axi_wvalid && s_axi_wready;
  endsequence
  a_aw_pulse: assert property (s_axi_awready |-> s_axi_awvalid ##1 !s_axi_awready)
    else $error("awready not a one-cycle answer to awvalid");
  a_wr_answer: assert property (s_wr_hs |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rd_answer: assert property (s_rd_hs |=> s_axi_rvalid)
    else $error("read data not one edge after address");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_reset_state: assert property ($rose(rst_n) |-> !irq_req_ff && irq_vector_ff == 14'h0000 && steal_grant_ff)
    else $error("outputs wrong after reset");
  a_vec_legal: assert property ($rose(irq_req_ff) |-> ##[0:1] (irq_vector_ff[1:0] == 2'h0 && irq_vector_ff >= 14'h0004 && irq_vector_ff <= 14'h002c))
    else $error("accepted vector outside table");
  a_pd_frozen: assert property (!steal_grant_ff |-> !clk_en_ff && stall_ff)
    else $error("core clock runs in power-down");
  a_idle_steal: assert property (steal_grant_ff || powerdown_acknowledge_pin_ff)
    else $error("cycle steals withheld outside power-down");
  a_run_clock: assert property (!stall_ff |-> clk_en_ff)
    else $error("clock divided while running");
  a_ctx_pulse: assert property (ctx_clear_ff |=> !ctx_clear_ff)
    else $error("context clear longer than one cycle");
endmodule // diic_asserts
bind diic_top diic_asserts diic_asserts_i (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_req_ff, .irq_vector_ff,
  .ctx_clear_ff, .stall_ff, .steal_grant_ff, .clk_en_ff, .powerdown_acknowledge_pin_ff);
`default_nettype wire

// ---- tb/diic_pin_model.sv ----
/*
  diic_pin_model: external devices on the request and power-down pins.
  assumes: pins active low with pull-ups; driven just after clk rises.
*/
`timescale 1ns/100ps
`default_nettype none
module diic_pin_model (
  input wire logic clk,
  output var diic_pkg::diic_pins_t pins
);
  import diic_pkg::*;
  localparam int gap_cyc = 8;
  initial pins = '1;
  task automatic hold(input int b, input logic lvl);
    pins[b] <= lvl;
    @(posedge clk);
  endtask
  // quiet gap after each edge so requests never outrun service
  task automatic pulse(input int b);
    pins[b] <= 1'b0;
    repeat (4) @(posedge clk);
    pins[b] <= 1'b1;
    repeat (gap_cyc) @(posedge clk);
  endtask
endmodule // diic_pin_model
`default_nettype wire

// ---- tb/test_diic_top.sv ----
/*
  test_diic_top: register-driven tests of the interrupt and idle controller.
  assumes: diic_top, diic_pin_model and the bound checker are compiled.
*/
`timescale 1ns/100ps
`default_nettype none
module test_diic_top;
  import diic_pkg::*;
  logic clk, rst_n, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
  logic irq_req_ff, ctx_clear_ff, stall_ff, steal_grant_ff, clk_en_ff, pdack;
  logic [31:0] awa, wd, ara, rdv, rdat;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] ws;
  logic [11:0] status_in, status_out_ff;
  logic [13:0] irq_vector_ff;
  diic_pins_t pins;
  diic_int_t int_ev;
  int failures, n_checks, t, n, cx;
  logic [13:0] vt [11] = '{14'h0004, 14'h0008, 14'h000c, 14'h0010, 14'h0014, 14'h0018,
    14'h001c, 14'h0020, 14'h0024, 14'h0028, 14'h0028};
  diic_top #(.rec_xtal_cyc(20)) diic_top_i (.clk, .rst_n, .pins, .int_ev, .status_in,
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdv), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .irq_req_ff, .irq_vector_ff, .status_out_ff, .ctx_clear_ff,
    .stall_ff, .steal_grant_ff, .clk_en_ff, .powerdown_acknowledge_pin_ff(pdack));
  diic_pin_model diic_pin_model_i (.clk, .pins);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_max(input string nm, input int lim, input int g);
    n_checks++;
    if (g > lim) begin
      failures++;
      $display("mismatch %s expected at most %0d seen %0d", nm, lim, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awa <= {24'h0, a};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!ta || !tw) begin
      @(posedge clk);
      if (awv && awr) begin
        ta = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wr_r) begin
        tw = 1'b1;
        wv <= 1'b0;
      end
    end
    while (bv !== 1'b1) @(posedge clk);
    resp = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    ara <= {24'h0, a};
    arv <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rdat = rdv;
    resp = rresp;
  endtask
  task automatic take(input logic [13:0] v);
    t = 0;
    while (irq_req_ff !== 1'b1 && t < 300) begin
      @(posedge clk);
      t++;
    end
    @(posedge clk);
    chk("irq_req", 32'h1, 32'(irq_req_ff));
    chk("vector", 32'(v), 32'(irq_vector_ff));
    wr(diic_adr_cmd, 32'h1 << diic_cmd_ack);
  endtask
  // return from service; the pushed status must come back
  task automatic done;
    wr(diic_adr_cmd, 32'h1 << diic_cmd_rti);
    @(posedge clk);
    chk("status", 32'(status_in), 32'(status_out_ff));
  endtask
  task automatic quiet;
    repeat (12) @(posedge clk);
    chk("no_irq", 32'h0, 32'(irq_req_ff));
  endtask
  task automatic test_done;
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    test_done;
  end
  initial begin
    rst_n = 1'b0;
    {awv, wv, arv, awa, wd, ara} = '0;
    {br, rr, ws} = '1;
    int_ev = '0;
    status_in = 12'ha5c;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(diic_adr_stat);
    chk("gie", 32'h1, 32'(rdat[19]));
    chk("stack_ptr", 32'h0, 32'(rdat[27:24]));
    rd(diic_adr_vec);
    chk("vec_reset", 32'h0, 32'(rdat[13:0]));
    rd(8'h18);
    chk("rd_unmapped", 32'(diic_resp_slverr), 32'(resp));
    wr(8'h18, 32'h1);
    chk("wr_unmapped", 32'(diic_resp_slverr), 32'(resp));
    // all forced at once: service order is the priority order
    wr(diic_adr_mask, 32'h7ff);
    wr(diic_adr_fclr, 32'h7ff);
    for (int i = 0; i < 11; i++) begin
      take(vt[i]);
      wr(diic_adr_fclr, 32'h1 << (16 + i));
      done;
    end
    wr(diic_adr_mask, 32'h1 << 9);
    wr(diic_adr_fclr, 32'h208);
    take(14'h0028);
    wr(diic_adr_fclr, 32'h1 << 19);
    done;
    wr(diic_adr_mask, 32'h1 << 3);
    quiet;
    wr(diic_adr_mask, 32'h1);
    wr(diic_adr_cmd, 32'h1 << diic_cmd_dis);
    wr(diic_adr_fclr, 32'h1);
    quiet;
    wr(diic_adr_cmd, 32'h1 << diic_cmd_ena);
    take(14'h0004);
    wr(diic_adr_fclr, 32'h1 << 16);
    done;
    wr(diic_adr_mask, 32'h1 << 2);
    diic_pin_model_i.hold(5, 1'b0);
    take(14'h000c);
    diic_pin_model_i.hold(5, 1'b1);
    done;
    quiet;
    wr(diic_adr_mask, 32'h1 << 5);
    diic_pin_model_i.pulse(3);
    take(14'h0018);
    done;
    quiet;
    wr(diic_adr_ctrl, 32'h10);
    wr(diic_adr_mask, 32'h1 << 8);
    diic_pin_model_i.pulse(2);
    take(14'h0024);
    done;
    wr(diic_adr_mask, 32'h1 << 9);
    for (int k = 0; k < 5; k++) begin
      n = (k == 0) ? 1 : (8 << k);
      wr(diic_adr_cmd, (32'(k) << diic_cmd_div_lo) | (32'h1 << diic_cmd_idle));
      repeat (20) @(posedge clk);
      chk("idle_stall", 32'h1, 32'(stall_ff));
      wr(diic_adr_fclr, 32'h1 << 9);
      t = 0;
      while (stall_ff !== 1'b0 && t < 400) begin
        @(posedge clk);
        t++;
      end
      chk_max("wake", n + 6, t);
      take(14'h0028);
      wr(diic_adr_fclr, 32'h1 << 25);
      done;
    end
    wr(diic_adr_mask, 32'h0);
    diic_pin_model_i.pulse(0);
    take(14'h002c);
    done;
    wr(diic_adr_ctrl, 32'h20);
    wr(diic_adr_cmd, 32'h1 << diic_cmd_pwdf);
    repeat (8) @(posedge clk);
    chk("pd_ack", 32'h1, 32'(pdack));
    chk("pd_grant", 32'h0, 32'(steal_grant_ff));
    diic_pin_model_i.hold(0, 1'b0);
    t = 0;
    cx = 0;
    while (pdack !== 1'b0 && t < 1000) begin
      @(posedge clk);
      t++;
      if (ctx_clear_ff === 1'b1) cx = 1;
    end
    diic_pin_model_i.hold(0, 1'b1);
    chk_max("recovery", 410, t);
    chk("recovery_ran", 32'h1, 32'(t >= 300));
    chk("ctx_clear", 32'h1, 32'(cx));
    // stopped-crystal recovery uses the shortened sim count of 20
    wr(diic_adr_ctrl, 32'h1 << diic_ctl_xtal);
    wr(diic_adr_cmd, 32'h1 << diic_cmd_pwdf);
    repeat (8) @(posedge clk);
    chk("pd_clk", 32'h0, 32'(clk_en_ff));
    diic_pin_model_i.hold(0, 1'b0);
    t = 0;
    while (pdack !== 1'b0 && t < 1000) begin
      @(posedge clk);
      t++;
    end
    diic_pin_model_i.hold(0, 1'b1);
    chk_max("recovery_xtal", 26, t);
    chk("recovery_xtal_ran", 32'h1, 32'(t >= 20));
    chk("run_clk", 32'h1, 32'(clk_en_ff));
    wr(diic_adr_cmd, 32'h1 << diic_cmd_pwdf);
    repeat (8) @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("rst_ends_pd", 32'h0, 32'(pdack));
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    test_done;
  end
endmodule // test_diic_top
`default_nettype wire
